// ### tsl_pkg.sv
// constants, defaults and carrier types for the touch scan sequencer
// assumes one 200 MHz clock shared by bus, sense front and nvm port
package tsl_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 200;
  localparam int SCAN_UNIT_MS = 15;
  localparam int FADE_UNIT_MS = 1;
  localparam int US_PER_MS = 1000;

  // ****************************************
  // sizes
  // ****************************************
  localparam int N_SENSE = 12;
  localparam int N_PIN = 8;
  localparam int CFG_AW = 6;
  localparam int CFG_N = 47;

  // ****************************************
  // configuration offsets
  // ****************************************
  localparam logic [7:0] OFS_EN_LO = 8'h00;
  localparam logic [7:0] OFS_EN_HI = 8'h01;
  localparam logic [7:0] OFS_ACT_PER = 8'h02;
  localparam logic [7:0] OFS_DOZE_PER = 8'h03;
  localparam logic [7:0] OFS_TIMEOUT = 8'h04;
  localparam logic [7:0] OFS_MODE_FORCE = 8'h05;
  localparam logic [7:0] OFS_AUTO_LIGHT = 8'h06;
  localparam logic [7:0] OFS_PMODE_LO = 8'h07;
  localparam logic [7:0] OFS_PMODE_HI = 8'h08;
  localparam logic [7:0] OFS_HOST_LVL = 8'h09;
  localparam logic [7:0] OFS_FADE_LIN = 8'h0a;
  localparam logic [7:0] OFS_FADE_IVL = 8'h0b;
  localparam logic [7:0] OFS_FADE_START = 8'h0c;
  localparam logic [7:0] OFS_FADE_END = 8'h0d;
  localparam logic [7:0] OFS_HYST = 8'h0e;
  localparam logic [7:0] OFS_DUTY0 = 8'h0f;
  localparam logic [7:0] OFS_THR0 = 8'h17;
  localparam logic [7:0] OFS_GAIN0 = 8'h23;

  // ****************************************
  // status offsets
  // ****************************************
  localparam logic [7:0] OFS_TOUCH_LO = 8'h40;
  localparam logic [7:0] OFS_TOUCH_HI = 8'h41;
  localparam logic [7:0] OFS_DIN_LEVEL = 8'h42;
  localparam logic [7:0] OFS_STATE = 8'h43;

  // ****************************************
  // encodings and factory defaults
  // ****************************************
  localparam logic [1:0] FORCE_AUTO = 2'h0;
  localparam logic [1:0] FORCE_ACTIVE = 2'h1;
  localparam logic [1:0] FORCE_DOZE = 2'h2;
  localparam logic [1:0] FORCE_SLEEP = 2'h3;
  localparam logic [1:0] PM_FADE = 2'h0;
  localparam logic [1:0] PM_DUTY = 2'h1;
  localparam logic [7:0] DEF_ACT_PER = 8'h02;
  localparam logic [7:0] DEF_DOZE_PER = 8'h0d;
  localparam logic [7:0] DEF_TIMEOUT = 8'h64;
  localparam logic [7:0] DEF_FADE_IVL = 8'h04;
  localparam logic [7:0] DEF_THR = 8'h40;
  localparam logic [7:0] DEF_GAIN = 8'h04;
  localparam logic [7:0] DEF_HYST = 8'h08;

  typedef enum logic [1:0] {MODE_ACTIVE, MODE_DOZE, MODE_SLEEP} tsl_mode_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsl_bus_req_t;

  typedef struct packed {
    logic start;
    logic [3:0] channel;
    logic [7:0] gain;
  } tsl_sense_req_t;

  typedef struct packed {
    logic done;
    logic [7:0] ticks;
  } tsl_sense_res_t;

  function automatic logic [7:0] tsl_cfg_default(input int idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == int'(OFS_EN_LO) || idx == int'(OFS_AUTO_LIGHT) || idx == int'(OFS_FADE_END)) v = 8'hff;
    else if (idx == int'(OFS_EN_HI)) v = 8'h0f;
    else if (idx == int'(OFS_ACT_PER)) v = DEF_ACT_PER;
    else if (idx == int'(OFS_DOZE_PER)) v = DEF_DOZE_PER;
    else if (idx == int'(OFS_TIMEOUT)) v = DEF_TIMEOUT;
    else if (idx == int'(OFS_FADE_IVL)) v = DEF_FADE_IVL;
    else if (idx == int'(OFS_HYST)) v = DEF_HYST;
    else if (idx >= int'(OFS_GAIN0)) v = DEF_GAIN;
    else if (idx >= int'(OFS_THR0)) v = DEF_THR;
    return v;
  endfunction

endpackage

// ### tsl_top.sv
// scan sequencer, operating modes and led fading of the touch controller
// assumes sense front, nvm and register master all run on clk
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1 - sense, process, timer phases repeat
// RULE2 - measure enabled inputs zero to eleven
// RULE3 - processing updates pins and status
// RULE4 - timer phase idles until period ends
// RULE5 - period from 15 ms upward
// RULE6 - visible updates only in processing; in sleep the code updates din_level and mode directly
// RULE7 - alert host on new button news
// RULE8 - three modes: active, doze, sleep
// RULE9 - active uses fast 30 ms period
// RULE10 - doze uses slow 195 ms period
// RULE11 - sleep: no scanning, inputs still live
// RULE12 - active and doze periods configurable
// RULE13 - inactivity time-out drops to doze
// RULE14 - eight pwm generators, 256 steps
// RULE15 - fade in/out, log or linear
// RULE16 - auto lighting: touch starts fade
// RULE17 - host level high starts fade
// RULE18 - host duty drives pwm directly
// RULE19 - pin usable as digital input
// RULE20 - boot from nvm, host may overwrite
// RULE21 - factory map sensor to own led
// RULE22 - per-sensor gain and threshold
// RULE23 - doze touch returns to active
// RULE24 - host may force the mode
// RULE25 - touch restarts inactivity count
module tsl_top import tsl_pkg::*; #(
  parameter int SCAN_UNIT_CYCLES = SCAN_UNIT_MS * US_PER_MS * CLK_MHZ,
  parameter int FADE_UNIT_CYCLES = FADE_UNIT_MS * US_PER_MS * CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire tsl_bus_req_t bus,
  output logic [7:0] reg_rdata,
  output tsl_sense_req_t sense_req,
  input wire tsl_sense_res_t sense_res,
  output logic sense_front_enable,
  output logic [CFG_AW-1:0] nvm_rd_addr,
  input wire logic [7:0] nvm_rd_data,
  output logic host_alert_n,
  input wire logic [N_PIN-1:0] pin_in,
  output logic [N_PIN-1:0] pin_out,
  output logic [N_PIN-1:0] pin_oe_n
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] scan_len(input logic [7:0] code);
    // code zero would mean a zero period, so it is held at the minimum
    return (code == 8'h00) ? 32'(SCAN_UNIT_CYCLES) : 32'(code) * 32'(SCAN_UNIT_CYCLES);
  endfunction

  function automatic logic touch_eval(input logic prev, input logic [7:0] ticks,
                                      input logic [7:0] thr, input logic [7:0] hyst);
    logic [8:0] hi;
    logic [8:0] lo;
    hi = {1'b0, thr} + {1'b0, hyst};
    lo = (thr > hyst) ? {1'b0, thr - hyst} : 9'h000;
    return prev ? ({1'b0, ticks} >= lo) : ({1'b0, ticks} >= hi);
  endfunction

  function automatic logic [7:0] fade_move(input logic [7:0] cur, input logic [7:0] tgt,
                                           input logic lin);
    logic [7:0] step;
    step = lin ? 8'h01 : {3'h0, cur[7:3]} + 8'h01;
    if (tgt > cur) return ((tgt - cur) <= step) ? tgt : cur + step;
    if (cur > tgt) return ((cur - tgt) <= step) ? tgt : cur - step;
    return cur;
  endfunction

  function automatic logic [1:0] pin_mode(input logic [7:0] lo, input logic [7:0] hi,
                                          input int i);
    logic [15:0] both;
    both = {hi, lo};
    return both[2*i +: 2];
  endfunction

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {ST_BOOT, ST_SENSE, ST_WAIT, ST_PROC, ST_TIMER, ST_SLEEP} tsl_state_t;

  tsl_state_t state;
  tsl_mode_t mode;
  tsl_mode_t next_mode;
  logic [7:0] cfg [CFG_N];
  logic boot_busy;
  logic boot_vld;
  logic [CFG_AW-1:0] boot_idx;
  logic [CFG_AW-1:0] boot_widx;
  logic [3:0] scan_idx;
  logic [31:0] period_cnt;
  logic [31:0] fade_cnt;
  logic fade_tick;
  logic [N_SENSE-1:0] raw_touch;
  logic [N_SENSE-1:0] touch_status;
  logic [N_PIN-1:0] din_level;
  logic [N_PIN-1:0] pin_on;
  logic [7:0] level [N_PIN];
  logic [7:0] pwm_cnt;
  logic [N_PIN-1:0] pin_meta;
  logic [N_PIN-1:0] pin_sync;
  logic alert;
  logic [7:0] idle_cnt;
  logic [N_SENSE-1:0] enabled;
  logic host_cfg_we;
  logic [CFG_AW-1:0] host_idx;
  logic [7:0] thr;
  logic [7:0] gain;
  logic [31:0] len;
  logic last_idx;
  logic alert_clr;

  assign enabled = {cfg[OFS_EN_HI[CFG_AW-1:0]][3:0], cfg[OFS_EN_LO[CFG_AW-1:0]]};
  assign host_idx = bus.addr[CFG_AW-1:0];
  assign host_cfg_we = bus.we && (bus.addr < 8'(CFG_N)) && !boot_busy && !boot_vld;
  assign thr = cfg[OFS_THR0[CFG_AW-1:0] + {2'h0, scan_idx}];
  assign gain = cfg[OFS_GAIN0[CFG_AW-1:0] + {2'h0, scan_idx}];
  assign len = scan_len((mode == MODE_DOZE) ? cfg[OFS_DOZE_PER[CFG_AW-1:0]]
                                            : cfg[OFS_ACT_PER[CFG_AW-1:0]]); // RULE9 RULE10 RULE12
  assign last_idx = (scan_idx == 4'(N_SENSE - 1));
  assign alert_clr = bus.re && (bus.addr == OFS_TOUCH_LO);
  assign nvm_rd_addr = boot_idx;
  assign host_alert_n = !alert;

  // ****************************************
  // boot load and configuration store
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_busy <= 1'b1;
      boot_idx <= '0;
      boot_vld <= 1'b0;
      boot_widx <= '0;
    end else begin
      boot_vld <= boot_busy;
      boot_widx <= boot_idx;
      if (boot_busy) begin
        if (boot_idx == CFG_AW'(CFG_N - 1)) boot_busy <= 1'b0;
        else boot_idx <= boot_idx + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < CFG_N; i++) begin
      if (rst) cfg[i] <= tsl_cfg_default(i); // RULE21
      else if (boot_vld && boot_widx == CFG_AW'(i)) cfg[i] <= nvm_rd_data; // RULE20
      else if (host_cfg_we && host_idx == CFG_AW'(i)) cfg[i] <= bus.wdata; // RULE20 RULE24
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) reg_rdata <= 8'h00;
    else if (!bus.re) reg_rdata <= 8'h00;
    else if (bus.addr < 8'(CFG_N)) reg_rdata <= cfg[host_idx];
    else if (bus.addr == OFS_TOUCH_LO) reg_rdata <= touch_status[7:0];
    else if (bus.addr == OFS_TOUCH_HI) reg_rdata <= {4'h0, touch_status[N_SENSE-1:8]};
    else if (bus.addr == OFS_DIN_LEVEL) reg_rdata <= din_level;
    else if (bus.addr == OFS_STATE) reg_rdata <= {3'h0, alert, 2'h0, mode};
    else reg_rdata <= 8'h00;
  end

  // ****************************************
  // scan sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_BOOT;
      scan_idx <= 4'h0;
      sense_req <= '0;
    end else begin
      sense_req.start <= 1'b0;
      case (state)
        ST_BOOT: begin
          if (!boot_busy && !boot_vld) state <= ST_SENSE;
        end
        ST_SENSE: begin
          if (enabled[scan_idx]) begin // RULE2
            sense_req.start <= 1'b1;
            sense_req.channel <= scan_idx;
            sense_req.gain <= gain; // RULE22
            state <= ST_WAIT;
          end else if (last_idx) begin
            state <= ST_PROC; // RULE1
          end else begin
            scan_idx <= scan_idx + 1'b1; // RULE2
          end
        end
        ST_WAIT: begin
          if (sense_res.done) begin
            if (last_idx) state <= ST_PROC; // RULE1
            else begin
              scan_idx <= scan_idx + 1'b1;
              state <= ST_SENSE;
            end
          end
        end
        ST_PROC: state <= ST_TIMER; // RULE1
        ST_TIMER: begin
          // low power wait; a long period is counted from the scan start
          if (period_cnt >= len - 32'h1) begin // RULE4 RULE5
            scan_idx <= 4'h0;
            state <= (mode == MODE_SLEEP) ? ST_SLEEP : ST_SENSE; // RULE1 RULE11
          end
        end
        ST_SLEEP: begin
          if (mode != MODE_SLEEP) begin
            scan_idx <= 4'h0;
            state <= ST_SENSE;
          end
        end
        default: state <= ST_BOOT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) period_cnt <= 32'h0;
    else if (state == ST_BOOT || state == ST_SLEEP) period_cnt <= 32'h0;
    else if (state == ST_TIMER && period_cnt >= len - 32'h1) period_cnt <= 32'h0;
    else period_cnt <= period_cnt + 32'h1;
  end

  always_ff @(posedge clk) begin
    if (rst) sense_front_enable <= 1'b0;
    else sense_front_enable <= (state == ST_SENSE || state == ST_WAIT); // RULE4 RULE11
  end

  // ****************************************
  // touch detection and status
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) raw_touch <= '0;
    else if (state == ST_WAIT && sense_res.done)
      raw_touch[scan_idx] <= touch_eval(raw_touch[scan_idx], sense_res.ticks, thr,
                                        cfg[OFS_HYST[CFG_AW-1:0]]); // RULE22
    else if (state == ST_SENSE && !enabled[scan_idx]) raw_touch[scan_idx] <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) touch_status <= '0;
    else if (state == ST_PROC) touch_status <= raw_touch; // RULE3 RULE6
  end

  // host read of the low touch byte clears; a new event in that cycle wins
  always_ff @(posedge clk) begin
    if (rst) alert <= 1'b0;
    else if (state == ST_PROC && raw_touch != touch_status) alert <= 1'b1; // RULE7 RULE6
    else if (alert_clr) alert <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // in sleep there is no processing phase, so input levels follow directly
  always_ff @(posedge clk) begin
    if (rst) din_level <= '0;
    else if (state == ST_PROC || state == ST_SLEEP) din_level <= pin_sync; // RULE19 RULE11
  end

  // ****************************************
  // operating mode
  // ****************************************
  always_comb begin
    next_mode = mode;
    case (cfg[OFS_MODE_FORCE[CFG_AW-1:0]][1:0]) // RULE24
      FORCE_ACTIVE: next_mode = MODE_ACTIVE;
      FORCE_DOZE: next_mode = MODE_DOZE;
      FORCE_SLEEP: next_mode = MODE_SLEEP;
      default: begin
        if (mode == MODE_SLEEP) next_mode = MODE_ACTIVE;
        else if (mode == MODE_DOZE && |raw_touch) next_mode = MODE_ACTIVE; // RULE23
        else if (mode == MODE_ACTIVE && cfg[OFS_TIMEOUT[CFG_AW-1:0]] != 8'h00 &&
                 idle_cnt >= cfg[OFS_TIMEOUT[CFG_AW-1:0]]) next_mode = MODE_DOZE; // RULE13
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) mode <= MODE_ACTIVE;
    else if (state == ST_PROC || state == ST_SLEEP) mode <= next_mode; // RULE8
  end

  // idle count is in scan periods and saturates
  always_ff @(posedge clk) begin
    if (rst) idle_cnt <= 8'h00;
    else if (state == ST_PROC) begin
      if (|raw_touch || mode != MODE_ACTIVE) idle_cnt <= 8'h00; // RULE25
      else if (idle_cnt != 8'hff) idle_cnt <= idle_cnt + 8'h01; // RULE13
    end
  end

  // ****************************************
  // led fading and pwm
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) pin_on <= '0;
    else if (state == ST_PROC) begin
      for (int i = 0; i < N_PIN; i++) begin
        if (cfg[OFS_AUTO_LIGHT[CFG_AW-1:0]][i]) pin_on[i] <= raw_touch[i]; // RULE16
        else pin_on[i] <= cfg[OFS_HOST_LVL[CFG_AW-1:0]][i]; // RULE17 RULE6
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fade_cnt <= 32'h0;
      fade_tick <= 1'b0;
    end else if (fade_cnt >= (32'(cfg[OFS_FADE_IVL[CFG_AW-1:0]]) + 32'h1) *
                             32'(FADE_UNIT_CYCLES) - 32'h1) begin
      fade_cnt <= 32'h0;
      fade_tick <= 1'b1; // RULE15
    end else begin
      fade_cnt <= fade_cnt + 32'h1;
      fade_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < N_PIN; i++) begin
      if (rst) level[i] <= 8'h00;
      else if (fade_tick)
        level[i] <= fade_move(level[i], pin_on[i] ? cfg[OFS_FADE_END[CFG_AW-1:0]]
                                                  : cfg[OFS_FADE_START[CFG_AW-1:0]],
                              cfg[OFS_FADE_LIN[CFG_AW-1:0]][0]); // RULE15 RULE17
    end
  end

  always_ff @(posedge clk) begin
    if (rst) pwm_cnt <= 8'h00;
    else pwm_cnt <= pwm_cnt + 8'h01; // RULE14
  end

  // duty 8'hff leaves one low slot per cycle: full on is 255 of 256
  always_ff @(posedge clk) begin
    for (int i = 0; i < N_PIN; i++) begin
      if (rst) begin
        pin_out[i] <= 1'b0;
        pin_oe_n[i] <= 1'b1;
      end else begin
        case (pin_mode(cfg[OFS_PMODE_LO[CFG_AW-1:0]], cfg[OFS_PMODE_HI[CFG_AW-1:0]], i))
          PM_FADE: begin
            pin_out[i] <= pwm_cnt < level[i]; // RULE14 RULE15
            pin_oe_n[i] <= 1'b0;
          end
          PM_DUTY: begin
            pin_out[i] <= pwm_cnt < cfg[OFS_DUTY0[CFG_AW-1:0] + CFG_AW'(i)]; // RULE18
            pin_oe_n[i] <= 1'b0;
          end
          default: begin
            pin_out[i] <= 1'b0;
            pin_oe_n[i] <= 1'b1; // RULE19
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### tsl_scan_properties.sv
// port checker for the touch scan sequencer
// assumes it is bound to tsl_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module tsl_scan_properties import tsl_pkg::*; #(
  parameter int SCAN_UNIT_CYCLES = 50,
  parameter int FADE_UNIT_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire tsl_bus_req_t bus,
  input wire logic [7:0] reg_rdata,
  input wire tsl_sense_req_t sense_req,
  input wire tsl_sense_res_t sense_res,
  input wire logic sense_front_enable,
  input wire logic [CFG_AW-1:0] nvm_rd_addr,
  input wire logic [7:0] nvm_rd_data,
  input wire logic host_alert_n,
  input wire logic [N_PIN-1:0] pin_in,
  input wire logic [N_PIN-1:0] pin_out,
  input wire logic [N_PIN-1:0] pin_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ********
  // channel history, cleared between sensing phases
  // ********
  logic have_prev;
  logic [3:0] prev_ch;
  always_ff @(posedge clk) begin
    if (rst || !sense_front_enable) begin
      have_prev <= 1'b0;
    end else if (sense_req.start) begin
      have_prev <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (sense_req.start) begin
      prev_ch <= sense_req.channel;
    end
  end
  // ********
  // properties
  // ********
  AST_RDATA_IDLE:
    assert property (!$past(bus.re) |-> reg_rdata == 8'h00) else $error("stray read data");
  AST_START_PULSE:
    assert property (sense_req.start |=> !sense_req.start) else $error("start too long");
  AST_START_IN_SENSE:
    assert property (sense_req.start |-> sense_front_enable) else $error("start outside sensing");
  AST_CH_ASCEND:
    assert property (sense_req.start && have_prev |-> sense_req.channel > prev_ch)
    else $error("channel order broken");
  AST_CH_HELD:
    assert property (!sense_req.start |-> $stable(sense_req.channel) && $stable(sense_req.gain))
    else $error("channel or gain moved");
  AST_ALERT_IN_PROC:
    assert property ($fell(host_alert_n) |-> !sense_front_enable) else $error("alert in sensing");
  AST_ALERT_CLEAR:
    assert property (bus.re && bus.addr == OFS_TOUCH_LO && sense_front_enable ##1
      sense_front_enable [*2] |-> host_alert_n) else $error("alert not cleared");
  AST_BOOT_ADDR:
    assert property (nvm_rd_addr > 6'h00 && nvm_rd_addr < 6'h2e |=>
      nvm_rd_addr == $past(nvm_rd_addr) + 6'h01) else $error("boot address skipped");
  cover property (sense_req.start && sense_req.channel == 4'hb);
  cover property ($fell(host_alert_n));
  cover property ($rose(sense_front_enable));
endmodule
`default_nettype wire

// ### tsl_front_model.sv
// sense front and boot memory that face the scan sequencer
// assumes start is a one-cycle pulse and nvm data is read one edge late
`timescale 1ns/1ps
`default_nettype none
module tsl_front_model import tsl_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire tsl_sense_req_t sense_req,
  output tsl_sense_res_t sense_res,
  input wire logic slow,
  input wire logic [N_SENSE-1:0][7:0] ticks,
  input wire logic [CFG_AW-1:0] nvm_rd_addr,
  output logic [7:0] nvm_rd_data
);
  logic [3:0] wait_cnt;
  logic [3:0] ch;
  // ********
  // boot image: longer active period than factory so slow sensing still fits
  // ********
  function automatic logic [7:0] image(input int i);
    if (i == 0 || i == 6 || i == 13) return 8'hff;
    if (i == 1) return 8'h0f;
    if (i == 2 || i == 4) return 8'h03;
    if (i == 3) return 8'h06;
    if (i == 14) return 8'h08;
    if (i >= 35) return 8'h04;
    if (i >= 23) return 8'h40;
    return 8'h00;
  endfunction
  always_ff @(posedge clk) begin
    nvm_rd_data <= image(int'(nvm_rd_addr));
  end
  // ********
  // measurement: ticks of the asked channel, garbage between answers
  // ********
  always_ff @(posedge clk) begin
    sense_res.done <= 1'b0;
    sense_res.ticks <= ~sense_res.ticks;
    if (rst) begin
      wait_cnt <= 4'h0;
      sense_res.ticks <= 8'h5a;
    end else if (sense_req.start) begin
      wait_cnt <= slow ? 4'h5 : 4'h1;
      ch <= sense_req.channel;
    end else if (wait_cnt == 4'h1) begin
      wait_cnt <= 4'h0;
      sense_res.done <= 1'b1;
      sense_res.ticks <= ticks[ch];
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the touch scan sequencer
// assumes short scan and fade units and the boot image of the front model
`timescale 1ns/1ps
`default_nettype none
module tb_top import tsl_pkg::*; ;
  localparam int SCAN = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  tsl_bus_req_t bus = '0;
  logic [7:0] reg_rdata;
  tsl_sense_req_t sense_req;
  tsl_sense_res_t sense_res;
  logic sense_front_enable;
  logic [CFG_AW-1:0] nvm_rd_addr;
  logic [7:0] nvm_rd_data;
  logic host_alert_n;
  logic [N_PIN-1:0] pin_in = '0;
  logic [N_PIN-1:0] pin_out;
  logic [N_PIN-1:0] pin_oe_n;
  logic slow = 1'b0;
  logic [N_SENSE-1:0][7:0] ticks = '0;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int chq[$];
  int n;
  logic [7:0] d;
  tsl_top #(.SCAN_UNIT_CYCLES(SCAN), .FADE_UNIT_CYCLES(4)) u_tsl_top (.clk(clk), .rst(rst),
    .bus(bus), .reg_rdata(reg_rdata), .sense_req(sense_req), .sense_res(sense_res),
    .sense_front_enable(sense_front_enable), .nvm_rd_addr(nvm_rd_addr),
    .nvm_rd_data(nvm_rd_data), .host_alert_n(host_alert_n), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  tsl_front_model u_tsl_front_model (.clk(clk), .rst(rst), .sense_req(sense_req),
    .sense_res(sense_res), .slow(slow), .ticks(ticks), .nvm_rd_addr(nvm_rd_addr),
    .nvm_rd_data(nvm_rd_data));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ********
  // helpers
  // ********
  task automatic results();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (sense_req.start === 1'b1) begin
      chq.push_back(int'(sense_req.channel));
    end
    if (cyc == 30000) begin
      num_errors++;
      results();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{we: 1'b1, re: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    bus.we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus.re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic mode_is(input logic [7:0] m);
    rd(OFS_STATE);
    check("mode", d & 8'h03, m);
  endtask
  task automatic scan(input int k);
    repeat (k) @(negedge sense_front_enable);
    repeat (4) @(posedge clk);
  endtask
  task automatic duty(input int p);
    n = 0;
    repeat (256) begin
      @(posedge clk);
      n += int'(pin_out[p]);
    end
  endtask
  task automatic period(input int exp);
    realtime t;
    @(posedge sense_front_enable);
    t = $realtime;
    @(posedge sense_front_enable);
    n = int'(($realtime - t) / 5.0);
    check("scan period", 8'(n >= exp - 2 && n <= exp + 2), 8'h01);
  endtask
  // ********
  // tests
  // ********
  initial begin
    void'($urandom(98506));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wr(OFS_FADE_IVL, 8'h09);
    repeat (60) @(posedge clk);
    rd(OFS_FADE_IVL);
    check("boot fade interval", d, 8'h00);
    rd(8'h30);
    check("unmapped", d, 8'h00);
    wr(OFS_TOUCH_HI, 8'h0f);
    rd(OFS_TOUCH_HI);
    check("touch high", d, 8'h00);
    rd(OFS_TOUCH_LO);
    check("touch low", d, 8'h00);
    mode_is(8'h00);
    $display("test boot done");
    slow <= 1'b1;
    wr(OFS_EN_LO, 8'hf7);
    wr(OFS_EN_HI, 8'h0d);
    wr(OFS_TIMEOUT, 8'h00);
    period(3 * SCAN);
    @(negedge sense_front_enable);
    chq.delete();
    @(negedge sense_front_enable);
    n = 0;
    for (int i = 0; i < N_SENSE; i++) begin
      if (i != 3 && i != 9) begin
        check("channel", 8'(chq.size() > n ? chq[n] : 99), 8'(i));
        n++;
      end
    end
    check("channel count", 8'(chq.size()), 8'(n));
    wr(OFS_ACT_PER, 8'h04);
    @(posedge sense_front_enable);
    period(4 * SCAN);
    mode_is(8'h00);
    wr(OFS_ACT_PER, 8'h03);
    slow <= 1'b0;
    $display("test scan order done");
    ticks[0] <= 8'ha0;
    scan(2);
    check("alert on touch", 8'(host_alert_n), 8'h00);
    @(posedge sense_front_enable);
    rd(OFS_TOUCH_LO);
    check("touch status", d, 8'h01);
    @(posedge clk);
    #1 check("alert cleared", 8'(host_alert_n), 8'h01);
    wr(OFS_TIMEOUT, 8'h03);
    repeat (800) @(posedge clk);
    mode_is(8'h00);
    duty(0);
    check("faded in", 8'(n >= 250), 8'h01);
    ticks[0] <= 8'h10;
    scan(2);
    check("alert on release", 8'(host_alert_n), 8'h00);
    rd(OFS_TOUCH_LO);
    check("release status", d, 8'h00);
    repeat (200) @(posedge clk);
    duty(0);
    check("faded out", 8'(n), 8'h00);
    $display("test touch done");
    repeat (600) @(posedge clk);
    mode_is(8'h01);
    period(6 * SCAN);
    ticks[5] <= 8'ha0;
    scan(2);
    mode_is(8'h00);
    ticks[5] <= 8'h00;
    $display("test doze done");
    wr(OFS_PMODE_LO, 8'h04);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_DUTY0 + 8'h01, 8'($urandom_range(1, 254)));
      scan(1);
      duty(1);
      check("host duty", 8'(n), bus.wdata);
    end
    wr(OFS_AUTO_LIGHT, 8'h00);
    wr(OFS_HOST_LVL, 8'h04);
    scan(1);
    repeat (300) @(posedge clk);
    duty(2);
    check("host level fade", 8'(n >= 250), 8'h01);
    $display("test pwm done");
    wr(OFS_PMODE_HI, 8'h02);
    pin_in <= 8'($urandom());
    scan(2);
    check("pin direction", 8'(pin_oe_n[4]), 8'h01);
    rd(OFS_DIN_LEVEL);
    check("input level", d & 8'h10, pin_in & 8'h10);
    for (int m = 1; m < 4; m++) begin
      wr(OFS_MODE_FORCE, 8'(m));
      repeat (400) @(posedge clk);
      mode_is(8'(m - 1));
    end
    n = 0;
    repeat (600) begin
      @(posedge clk);
      n += int'(sense_front_enable);
    end
    check("sleep sensing", 8'(n), 8'h00);
    pin_in <= ~pin_in;
    repeat (8) @(posedge clk);
    rd(OFS_DIN_LEVEL);
    check("input asleep", d & 8'h10, pin_in & 8'h10);
    wr(OFS_MODE_FORCE, 8'h00);
    period(3 * SCAN);
    $display("test modes done");
    results();
  end
endmodule
bind tsl_top tsl_scan_properties #(.SCAN_UNIT_CYCLES(SCAN_UNIT_CYCLES),
  .FADE_UNIT_CYCLES(FADE_UNIT_CYCLES)) u_tsl_scan_properties (.clk(clk), .rst(rst), .bus(bus),
  .reg_rdata(reg_rdata), .sense_req(sense_req), .sense_res(sense_res),
  .sense_front_enable(sense_front_enable), .nvm_rd_addr(nvm_rd_addr),
  .nvm_rd_data(nvm_rd_data), .host_alert_n(host_alert_n), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n));
`default_nettype wire
